// File: src/irxb_top.v
// isochronous receive interrupt event and mask registers, summary
// receive interrupt, and initial bandwidth preset, behind an APB slave
// assumes: all inputs except the async reset_n synchronous to mclk; one APB master
`timescale 1ns/1ps
`default_nettype none
`include "irxb_defs.vh"

// How it works
// RULE_01: completed INPUT with interrupt raises context flag
// RULE_02: flag sets on rising edge or set write
// RULE_03: only clear-register one-writes clear a flag
// RULE_04: set at A0h, clear A4h reads masked
// RULE_05: event bits 31..4 read zero
// RULE_06: bits 3..0 map contexts 3..0, summary bit 7
// RULE_07: mask set/clear reads return mask contents
// RULE_08: mask bits align with event bits
// RULE_09: bandwidth field writable, 1333h on hardware/software reset
// RULE_10: bus reset keeps bandwidth field
// RULE_11: resets copy bandwidth field into CSR
// RULE_12: bandwidth bits 31..13 read zero
// RULE_13: summary interrupt needs event and main mask bit 7
// RULE_14: summary event holds while any unmasked flag
module irxb_top (
   input  wire        mclk,
   input  wire        reset_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [3:0]  rx_ctx_irq,
   input  wire        global_reset_input,
   input  wire        pcie_reset_input,
   input  wire        secondary_reset_input,
   input  wire        bus_reset,
   output reg         rx_dma_summary_event,
   output reg  [12:0] bw_available_csr,
   output reg         irq
);
   reg  [3:0]  rx_flag_r;
   reg  [3:0]  rx_flag_nxt;
   reg  [3:0]  rx_mask_r;
   reg  [3:0]  rx_mask_nxt;
   reg  [12:0] initial_bandwidth_value;
   reg         main_mask_r;
   reg         swrst_r;
   reg         swrst_d_r;
   reg  [31:0] rdata_nxt;
   reg         slverr_nxt;
   wire [3:0]  ctx_rise;
   wire        csr_load;
   wire        setup;
   wire        wr_acc;
   wire        wr_evt_set;
   wire        wr_evt_clr;
   wire        wr_msk_set;
   wire        wr_msk_clr;
   wire        wr_bw;
   wire        wr_ctrl;
   wire        summary_nxt;

   // address decode used by both the read mux and the write strobes
   function hit;
      input [11:0] a;
      input [11:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // interrupt lines rise when an INPUT with interrupt bits completes
   irxb_edge_det #(
      .W (`IRXB_NCTX)
   ) u_edge (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .level_in (rx_ctx_irq),
      .rise_out (ctx_rise)
   ); // see RULE_01

   irxb_reset_merge u_rmerge (
      .mclk                  (mclk),
      .reset_n               (reset_n),
      .global_reset_input    (global_reset_input),
      .pcie_reset_input      (pcie_reset_input),
      .secondary_reset_input (secondary_reset_input),
      .bus_reset             (bus_reset),
      .load_pulse            (csr_load)
   );

   // zero-wait slave: answer in the access cycle itself
   assign setup      = psel & ~penable;
   assign wr_acc     = psel & penable & pwrite;
   assign wr_evt_set = wr_acc & hit(paddr, `IRXB_OFF_EVT_SET);
   assign wr_evt_clr = wr_acc & hit(paddr, `IRXB_OFF_EVT_CLR);
   assign wr_msk_set = wr_acc & hit(paddr, `IRXB_OFF_MSK_SET);
   assign wr_msk_clr = wr_acc & hit(paddr, `IRXB_OFF_MSK_CLR);
   assign wr_bw      = wr_acc & hit(paddr, `IRXB_OFF_INIT_BW);
   assign wr_ctrl    = wr_acc & hit(paddr, `IRXB_OFF_CTRL);

   // set wins over clear so an edge in the clearing cycle survives
   always @* begin
      rx_flag_nxt = rx_flag_r;
      if (wr_evt_clr) begin
         rx_flag_nxt = rx_flag_nxt & ~pwdata[3:0]; // see RULE_03
      end
      rx_flag_nxt = rx_flag_nxt | ctx_rise; // see RULE_02
      if (wr_evt_set) begin
         rx_flag_nxt = rx_flag_nxt | pwdata[3:0]; // see RULE_02
      end
   end

   always @* begin
      rx_mask_nxt = rx_mask_r;
      if (wr_msk_clr) begin
         rx_mask_nxt = rx_mask_nxt & ~pwdata[3:0];
      end
      if (wr_msk_set) begin
         rx_mask_nxt = rx_mask_nxt | pwdata[3:0]; // see RULE_08
      end
   end

   // per-context flags feed summary bit 7 through the same-position mask
   assign summary_nxt = |(rx_flag_nxt & rx_mask_nxt); // see RULE_06

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_flag_r            <= `IRXB_EVT_RST;
         rx_mask_r            <= `IRXB_MSK_RST;
         rx_dma_summary_event <= 1'b0;
         irq                  <= 1'b0;
      end else begin
         rx_flag_r            <= rx_flag_nxt;
         rx_mask_r            <= rx_mask_nxt;
         rx_dma_summary_event <= summary_nxt; // see RULE_14
         irq <= summary_nxt & main_mask_r; // see RULE_13
      end
   end

   // control: software reset pulse and main mask bit 7
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         main_mask_r <= 1'b0;
         swrst_r     <= 1'b0;
         swrst_d_r   <= 1'b0;
      end else begin
         swrst_d_r <= swrst_r;
         if (wr_ctrl) begin
            main_mask_r <= pwdata[`IRXB_CTRL_MAINMSK_BIT];
            swrst_r     <= pwdata[`IRXB_CTRL_SWRST_BIT];
         end else begin
            swrst_r <= 1'b0;
         end
      end
   end

   // bus reset pin never touches the field itself
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         initial_bandwidth_value <= `IRXB_INIT_BW_RST; // see RULE_09
      end else if (swrst_r) begin
         initial_bandwidth_value <= `IRXB_INIT_BW_RST; // see RULE_09
      end else if (wr_bw) begin
         initial_bandwidth_value <= pwdata[12:0]; // see RULE_10
      end
   end

   // the CSR follows the preset one cycle after a software reset too,
   // so it sees the restored 1333h rather than the old field
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bw_available_csr <= `IRXB_INIT_BW_RST;
      end else if (csr_load | swrst_d_r) begin
         bw_available_csr <= initial_bandwidth_value; // see RULE_11
      end
   end

   // read mux; reserved bits come back as zero
   always @* begin
      rdata_nxt  = 32'h00000000;
      slverr_nxt = 1'b0;
      if (hit(paddr, `IRXB_OFF_EVT_SET)) begin
         rdata_nxt[3:0] = rx_flag_r; // see RULE_05
      end else if (hit(paddr, `IRXB_OFF_EVT_CLR)) begin
         rdata_nxt[3:0] = rx_flag_r & rx_mask_r; // see RULE_04
      end else if (hit(paddr, `IRXB_OFF_MSK_SET) |
                   hit(paddr, `IRXB_OFF_MSK_CLR)) begin
         rdata_nxt[3:0] = rx_mask_r; // see RULE_07
      end else if (hit(paddr, `IRXB_OFF_INIT_BW)) begin
         rdata_nxt[12:0] = initial_bandwidth_value; // see RULE_12
      end else if (hit(paddr, `IRXB_OFF_BW_CSR)) begin
         rdata_nxt[12:0] = bw_available_csr;
      end else if (hit(paddr, `IRXB_OFF_CTRL)) begin
         rdata_nxt[`IRXB_CTRL_MAINMSK_BIT] = main_mask_r;
      end else begin
         slverr_nxt = 1'b1;
      end
   end

   // registered answer: pready high in the access cycle following setup
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & slverr_nxt;
         if (setup & ~pwrite) begin
            prdata <= rdata_nxt;
         end
      end
   end
endmodule
`default_nettype wire

// File: src/irxb_defs.vh
// register map, field layouts and reset values of the receive
// interrupt and bandwidth register block
// assumes: included by the design files of this block only
`ifndef IRXB_DEFS_VH
`define IRXB_DEFS_VH

`define IRXB_OFF_EVT_SET      12'h0A0
`define IRXB_OFF_EVT_CLR      12'h0A4
`define IRXB_OFF_MSK_SET      12'h0A8
`define IRXB_OFF_MSK_CLR      12'h0AC
`define IRXB_OFF_INIT_BW      12'h0B0
`define IRXB_OFF_BW_CSR       12'h0B8
`define IRXB_OFF_CTRL         12'h0BC
`define IRXB_ADDR_W           12
`define IRXB_NCTX             4
`define IRXB_BW_W             13
`define IRXB_INIT_BW_RST      13'h1333
`define IRXB_EVT_RST          4'h0
`define IRXB_MSK_RST          4'h0
`define IRXB_CTRL_SWRST_BIT   0
`define IRXB_CTRL_BUSRST_BIT  1
`define IRXB_CTRL_MAINMSK_BIT 7

`endif

// File: src/irxb_edge_det.v
// rising edge detector for the per-context interrupt lines
// assumes: inputs synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module irxb_edge_det #(
   parameter W = 4
) (
   input  wire         mclk,
   input  wire         reset_n,
   input  wire [W-1:0] level_in,
   output wire [W-1:0] rise_out
);
   reg [W-1:0] prev_r;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prev_r <= {W{1'b0}};
      end else begin
         prev_r <= level_in;
      end
   end

   assign rise_out = level_in & ~prev_r;
endmodule
`default_nettype wire

// File: src/irxb_reset_merge.v
// merges the bandwidth CSR load requests into one pulse
// assumes: all request inputs synchronous to mclk, active high
`timescale 1ns/1ps
`default_nettype none
module irxb_reset_merge (
   input  wire mclk,
   input  wire reset_n,
   input  wire global_reset_input,
   input  wire pcie_reset_input,
   input  wire secondary_reset_input,
   input  wire bus_reset,
   output reg  load_pulse
);
   reg any_d_r;
   wire any_now;

   assign any_now = global_reset_input | pcie_reset_input |
                    secondary_reset_input | bus_reset;

   // one load per rise of the merged requests; the copy lands two edges after that leading edge
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         any_d_r    <= 1'b0;
         load_pulse <= 1'b0;
      end else begin
         any_d_r    <= any_now;
         load_pulse <= any_now & ~any_d_r;
      end
   end
endmodule
`default_nettype wire

// File: sim/irxb_sva.sv
// checker for irxb_top: apb answer, reserved bits, summary and irq
// assumes: bound to irxb_top, one clock, reset_n async active low
`timescale 1ns/1ps
`default_nettype none
module irxb_sva (
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  rx_ctx_irq,
   input wire logic        global_reset_input,
   input wire logic        pcie_reset_input,
   input wire logic        secondary_reset_input,
   input wire logic        bus_reset,
   input wire logic        rx_dma_summary_event,
   input wire logic [12:0] bw_available_csr,
   input wire logic        irq
);
   wire        wr_acc = psel && penable && pwrite;
   wire        rd_ok  = pready && !pwrite;
   logic [5:0] hist_r;
   // csr may only move a few edges after a load request
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         hist_r <= 6'h00;
      else
         hist_r <= {hist_r[4:0], global_reset_input | pcie_reset_input |
            secondary_reset_input | bus_reset | (wr_acc && paddr == 12'h0BC)};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   property p_rdy;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("pready not one cycle");
   property p_err;
      pready |-> pslverr == !(paddr inside {12'h0A0, 12'h0A4, 12'h0A8,
         12'h0AC, 12'h0B0, 12'h0B8, 12'h0BC});
   endproperty
   a_err: assert property (p_err) else $error("pslverr wrong");
   property p_evt_rsv;
      rd_ok && paddr[11:3] == 9'h014 |-> prdata[31:4] == 28'h0;
   endproperty
   a_evt_rsv: assert property (p_evt_rsv) else $error("event rsvd");
   property p_bw_rsv;
      rd_ok && paddr == 12'h0B0 |-> prdata[31:13] == 19'h0;
   endproperty
   a_bw_rsv: assert property (p_bw_rsv) else $error("bw rsvd");
   property p_hold;
      rx_dma_summary_event && !(wr_acc && (paddr == 12'h0A4 ||
         paddr == 12'h0AC)) |=> rx_dma_summary_event;
   endproperty
   a_hold: assert property (p_hold) else $error("summary dropped");
   property p_irq;
      irq |-> rx_dma_summary_event;
   endproperty
   a_irq: assert property (p_irq) else $error("irq without summary");
   property p_rise;
      $rose(rx_dma_summary_event) |-> $past(wr_acc) ||
         ($past(rx_ctx_irq) & ~$past(rx_ctx_irq, 2)) != 4'h0 ||
         ($past(rx_ctx_irq, 2) & ~$past(rx_ctx_irq, 3)) != 4'h0;
   endproperty
   a_rise: assert property (p_rise) else $error("summary w/o cause");
   property p_csr;
      $changed(bw_available_csr) |-> hist_r != 6'h00;
   endproperty
   a_csr: assert property (p_csr) else $error("csr moved alone");
endmodule
bind irxb_top irxb_sva chk_u (.mclk, .reset_n, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .rx_ctx_irq, .global_reset_input,
   .pcie_reset_input, .secondary_reset_input, .bus_reset,
   .rx_dma_summary_event, .bw_available_csr, .irq);
`default_nettype wire

// File: sim/tb_irxb_top.sv
// testbench: apb register tests of irxb_top
// assumes: irxb_sva bound to the design, 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_irxb_top;
   logic        mclk;
   logic        reset_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   logic [3:0]  rx_ctx_irq;
   logic [3:0]  rst_in;
   wire         rx_dma_summary_event;
   wire  [12:0] bw_available_csr;
   wire         irq;
   logic        last_err;
   int          num_errors;
   int          checks;
   irxb_top dut_u (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_ctx_irq,
      .global_reset_input(rst_in[0]), .pcie_reset_input(rst_in[1]),
      .secondary_reset_input(rst_in[2]), .bus_reset(rst_in[3]),
      .rx_dma_summary_event, .bw_available_csr, .irq);
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] e);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      last_err = pslverr;
      if (!w) cmp(prdata, e);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic give_verdict();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      #200000;
      num_errors++;
      give_verdict();
   end
   initial begin
      {reset_n, psel, penable, pwrite, rx_ctx_irq, rst_in} = 0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      xfer(0, 12'h0A0, 0, 0);
      xfer(0, 12'h0B0, 0, 32'h1333);
      xfer(1, 12'h0A8, 32'h5, 0);
      xfer(0, 12'h0AC, 0, 32'h5);
      @(posedge mclk);
      rx_ctx_irq <= 4'h3;
      repeat (3) @(posedge mclk);
      // context 1 stays high: a level must not set the flag again
      rx_ctx_irq <= 4'h2;
      xfer(0, 12'h0A0, 0, 32'h3);
      xfer(0, 12'h0A4, 0, 32'h1);
      cmp(irq, 0);
      xfer(1, 12'h0BC, 32'h80, 0);
      // irq follows the main mask one edge after the mask register
      repeat (2) @(posedge mclk);
      cmp({rx_dma_summary_event, irq}, 2'b11);
      xfer(1, 12'h0A0, 32'hFFFF_FFFF, 0);
      xfer(0, 12'h0A0, 0, 32'hF);
      xfer(0, 12'h0A4, 0, 32'h5);
      xfer(1, 12'h0A4, 32'h3, 0);
      xfer(0, 12'h0A0, 0, 32'hC);
      xfer(1, 12'h0AC, 32'h5, 0);
      xfer(0, 12'h0A8, 0, 0);
      cmp({rx_dma_summary_event, irq}, 0);
      xfer(1, 12'h0B0, 32'hFFFF_FFFF, 0);
      xfer(0, 12'h0B0, 0, 32'h1FFF);
      for (int i = 0; i < 4; i++) begin
         xfer(1, 12'h0B0, 32'h100 + i, 0);
         rst_in[i] <= 1'b1;
         repeat (4) @(posedge mclk);
         rst_in[i] <= 1'b0;
         cmp(bw_available_csr, 32'h100 + i);
      end
      xfer(0, 12'h0B0, 0, 32'h103);
      xfer(1, 12'h0BC, 32'h1, 0);
      repeat (6) @(posedge mclk);
      cmp(bw_available_csr, 32'h1333);
      xfer(0, 12'h0B8, 0, 32'h1333);
      xfer(0, 12'h0B0, 0, 32'h1333);
      xfer(0, 12'h0C0, 0, 0);
      cmp(last_err, 1);
      give_verdict();
   end
endmodule
`default_nettype wire
